// File: hw/video_format_framing_test_regs.sv
// Format, framing, aux extraction and test pattern register bank with its status logic.
// Assumes host port, datapath events and detector outputs are on the word clock;
// the realign permit arrives from a multifunction pin and is synchronised here.
`timescale 1ns/1ps
module video_format_framing_test_regs (
  input  wire logic                                     clock,
  input  wire logic                                     reset,
  input  wire video_regs_pkg::host_req_s                host_req,
  output logic [7:0]                                    host_rdata_r,
  input  wire logic [video_regs_pkg::AUX_OCC_WIDTH-1:0] aux_queue_occupancy,
  input  wire logic                                     aux_packet_header,
  input  wire logic                                     aux_packet_done,
  input  wire logic                                     aux_packet_id_parity_error,
  input  wire logic                                     aux_packet_on_vblank_line,
  input  wire logic                                     detect_valid,
  input  wire video_regs_pkg::format_code_e             detect_code,
  input  wire logic                                     trs_valid,
  input  wire logic                                     trs_on_boundary,
  input  wire video_regs_pkg::trs_flags_s               trs_flags,
  input  wire logic                                     self_check_done,
  input  wire logic                                     self_check_pass,
  input  wire logic                                     realign_input,
  output logic                                          aux_queue_near_full_flag_r,
  output logic                                          short_packet_flag_r,
  output logic                                          aux_packet_extract_r,
  output video_regs_pkg::format_code_e                  forced_format_r,
  output logic                                          forced_format_active_r,
  output video_regs_pkg::lock_range_e                   lock_range_r,
  output logic                                          new_sync_position_r,
  output logic                                          realign_r,
  output logic                                          word_aligned_r,
  output logic [5:0]                                    pattern_choice_r,
  output logic                                          generator_enable_r,
  output logic                                          self_check_run_r
);
  import video_regs_pkg::*;

  // Writable control state
  logic [7:0]   control_r,  control_nxt;
  logic [5:0]   pattern_nxt;
  logic         gen_nxt;
  logic [1:0]   aux_opt_r,  aux_opt_nxt;
  // Captured status
  format_code_e detected_r, detected_nxt;
  trs_flags_s   flags_r,    flags_nxt;
  logic         flags_seen_r, flags_seen_nxt;
  logic         pass_r,     pass_nxt;
  logic         in_packet_r, in_packet_nxt;
  logic         short_nxt;
  logic         near_full_nxt;
  logic         extract_nxt;
  logic [7:0]   rdata_nxt;
  format_code_e forced_nxt;
  logic         forced_active_nxt;
  lock_range_e  lock_nxt;
  logic         self_run_nxt;
  // Permit pin synchroniser
  logic         permit_meta_r;
  logic         permit_sync_r;

  logic wr_en;
  logic rd_en;
  logic short_read;
  logic nsp_int;
  logic realign_int;
  logic aligned_int;

  // Checks a code against the fourteen supported formats
  function automatic logic code_known(input logic [4:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      FMT_525_54, FMT_525_36, FMT_525_27, FMT_625_54, FMT_625_36, FMT_625_27,
      FMT_1035I, FMT_1080I30, FMT_1080P30, FMT_1080I25, FMT_1080P25,
      FMT_1250I25, FMT_1080P24, FMT_720P60: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Tells whether a pattern choice doubles as self-check data
  function automatic logic pattern_self_check(input logic [5:0] pat);
    logic ok;
    ok = (pat[PAT_HD_BIT] && pat[1:0] == PAT_BARS) ||
         (pat == PAT_SD_NTSC_BARS) || (pat == PAT_SD_PAL_PLL);
    return ok;
  endfunction

  assign wr_en      = host_req.sel && host_req.wr;
  assign rd_en      = host_req.sel && host_req.rd;
  assign short_read = rd_en && (host_req.addr == AUX_EXTRACT_OPTIONS_ADDR);

  // Register writes
  always_comb begin
    control_nxt = control_r;
    pattern_nxt = pattern_choice_r;
    gen_nxt     = generator_enable_r;
    aux_opt_nxt = aux_opt_r;
    if (wr_en) begin
      case (host_req.addr)
        VIDEO_STANDARD_CONTROL_ADDR: control_nxt = host_req.wdata;
        PATTERN_TEST_CONTROL_ADDR: begin
          pattern_nxt = host_req.wdata[5:0]; // see R23
          gen_nxt     = host_req.wdata[TEST_ENABLE_BIT];
        end
        AUX_EXTRACT_OPTIONS_ADDR: aux_opt_nxt = host_req.wdata[AUX_VBLANK_BIT:AUX_PARITY_OFF_BIT];
        default: control_nxt = control_r;
      endcase
    end
  end

  // Derived control outputs
  always_comb begin
    forced_nxt        = format_code_e'(control_r[4:0]);
    forced_active_nxt = code_known(control_r[4:0]); // see R5 R7
    if (control_r[CTL_HIGH_DEF_LOCK_ONLY_BIT] && !control_r[CTL_STANDARD_DEF_LOCK_ONLY_BIT]) begin
      lock_nxt = LOCK_HD; // see R8
    end else if (control_r[CTL_STANDARD_DEF_LOCK_ONLY_BIT] && !control_r[CTL_HIGH_DEF_LOCK_ONLY_BIT]) begin
      lock_nxt = LOCK_SD; // see R9
    end else begin
      lock_nxt = LOCK_BOTH; // see R10
    end
    self_run_nxt = generator_enable_r && pattern_self_check(pattern_choice_r); // see R20 R21
  end

  // Aux packet tracking, flags and extraction decision
  always_comb begin
    in_packet_nxt = in_packet_r;
    short_nxt     = short_packet_flag_r;
    if (short_read) begin
      short_nxt = 1'b0;
    end
    if (aux_packet_done) begin
      in_packet_nxt = 1'b0;
    end
    if (aux_packet_header) begin
      in_packet_nxt = 1'b1;
      if (in_packet_r && !aux_packet_done) begin
        short_nxt = 1'b1; // see R2
      end
    end
    near_full_nxt = (aux_queue_occupancy >= NEAR_FULL_LEVEL); // see R1
    extract_nxt   = aux_packet_header &&
                    (aux_opt_r[0] || !aux_packet_id_parity_error) && // see R3
                    (aux_opt_r[1] || !aux_packet_on_vblank_line); // see R4
  end

  // Detected format, timing flags and self-check result
  always_comb begin
    detected_nxt   = detected_r;
    flags_nxt      = flags_r;
    flags_seen_nxt = flags_seen_r;
    pass_nxt       = pass_r;
    if (detect_valid) begin
      detected_nxt = detect_code; // see R17 R18
    end
    if (trs_valid && (!flags_seen_r || trs_flags.f != flags_r.f)) begin
      flags_nxt      = trs_flags; // see R19
      flags_seen_nxt = 1'b1;
    end
    if (self_check_done) begin
      pass_nxt = self_check_pass; // see R22
    end
  end

  // Read data, undefined bits zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd_en) begin
      case (host_req.addr)
        VIDEO_STANDARD_CONTROL_ADDR: rdata_nxt = control_r;
        VIDEO_STANDARD_STATUS_ADDR:  rdata_nxt = {flags_r.f, flags_r.v, flags_r.h, detected_r};
        PATTERN_TEST_CONTROL_ADDR:   rdata_nxt = {pass_r, generator_enable_r, pattern_choice_r};
        AUX_EXTRACT_OPTIONS_ADDR:    rdata_nxt = {4'h0, aux_opt_r, short_packet_flag_r,
                                                  aux_queue_near_full_flag_r}; // see R24
        default:                     rdata_nxt = 8'h00;
      endcase
    end
  end

  // All registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control_r                  <= VIDEO_STANDARD_CONTROL_RESET; // see R16
      pattern_choice_r           <= PATTERN_RESET;
      generator_enable_r         <= 1'b0;
      aux_opt_r                  <= AUX_OPTIONS_RESET;
      detected_r                 <= FMT_NONE;
      flags_r                    <= '0;
      flags_seen_r               <= 1'b0;
      pass_r                     <= 1'b0;
      in_packet_r                <= 1'b0;
      short_packet_flag_r        <= 1'b0;
      aux_queue_near_full_flag_r <= 1'b0;
      aux_packet_extract_r       <= 1'b0;
      host_rdata_r               <= 8'h00;
      forced_format_r            <= FMT_NONE;
      forced_format_active_r     <= 1'b0;
      lock_range_r               <= LOCK_BOTH;
      self_check_run_r           <= 1'b0;
      permit_meta_r              <= 1'b0;
      permit_sync_r              <= 1'b0;
      new_sync_position_r        <= 1'b0;
      realign_r                  <= 1'b0;
      word_aligned_r             <= 1'b0;
    end else begin
      control_r                  <= control_nxt;
      pattern_choice_r           <= pattern_nxt;
      generator_enable_r         <= gen_nxt;
      aux_opt_r                  <= aux_opt_nxt;
      detected_r                 <= detected_nxt;
      flags_r                    <= flags_nxt;
      flags_seen_r               <= flags_seen_nxt;
      pass_r                     <= pass_nxt;
      in_packet_r                <= in_packet_nxt;
      short_packet_flag_r        <= short_nxt;
      aux_queue_near_full_flag_r <= near_full_nxt;
      aux_packet_extract_r       <= extract_nxt;
      host_rdata_r               <= rdata_nxt;
      forced_format_r            <= forced_nxt;
      forced_format_active_r     <= forced_active_nxt;
      lock_range_r               <= lock_nxt;
      self_check_run_r           <= self_run_nxt;
      permit_meta_r              <= realign_input;
      permit_sync_r              <= permit_meta_r;
      new_sync_position_r        <= nsp_int;
      realign_r                  <= realign_int;
      word_aligned_r             <= aligned_int;
    end
  end

  // Framing decision on the synchronised permit
  framing_ctrl u_framing (
    .clock               (clock),
    .reset               (reset),
    .trs_valid           (trs_valid),
    .trs_on_boundary     (trs_on_boundary),
    .policy              (control_r[CTL_POLICY_BIT]),
    .permit              (permit_sync_r),
    .aligned_r           (aligned_int),
    .realign_r           (realign_int),
    .new_sync_position_r (nsp_int)
  );

  property p_near_full;
    @(posedge clock) disable iff (reset)
      (aux_queue_occupancy >= NEAR_FULL_LEVEL) |=> aux_queue_near_full_flag_r;
  endproperty
  a_near_full: assert property (p_near_full) else $error("near full missed"); // see R1

  property p_not_near_full;
    @(posedge clock) disable iff (reset)
      (aux_queue_occupancy < NEAR_FULL_LEVEL) |=> !aux_queue_near_full_flag_r;
  endproperty
  a_not_near_full: assert property (p_not_near_full) else $error("near full early"); // see R1

  property p_short_set;
    @(posedge clock) disable iff (reset)
      (aux_packet_header && in_packet_r && !aux_packet_done) |=> short_packet_flag_r;
  endproperty
  a_short_set: assert property (p_short_set) else $error("short packet not flagged"); // see R2

  property p_parity_refuse;
    @(posedge clock) disable iff (reset)
      (aux_packet_id_parity_error && !aux_opt_r[0]) |=> !aux_packet_extract_r;
  endproperty
  a_parity_refuse: assert property (p_parity_refuse) else $error("parity failing packet taken"); // see R3

  property p_vblank_refuse;
    @(posedge clock) disable iff (reset)
      (aux_packet_on_vblank_line && !aux_opt_r[1]) |=> !aux_packet_extract_r;
  endproperty
  a_vblank_refuse: assert property (p_vblank_refuse) else $error("blanking packet taken"); // see R4

  property p_lock_hd;
    @(posedge clock) disable iff (reset)
      (control_r[CTL_HIGH_DEF_LOCK_ONLY_BIT] && !control_r[CTL_STANDARD_DEF_LOCK_ONLY_BIT]) |=> (lock_range_r == LOCK_HD);
  endproperty
  a_lock_hd: assert property (p_lock_hd) else $error("hd lock range wrong"); // see R8

  property p_policy_reset;
    @(posedge clock) $fell(reset) |-> control_r[CTL_POLICY_BIT];
  endproperty
  a_policy_reset: assert property (p_policy_reset) else $error("policy not set after reset"); // see R16

  property p_flags_hold;
    @(posedge clock) disable iff (reset) (!trs_valid) |=> (flags_r == $past(flags_r));
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("timing flags changed"); // see R19

  property p_detect_store;
    @(posedge clock) disable iff (reset) detect_valid |=> (detected_r == $past(detect_code));
  endproperty
  a_detect_store: assert property (p_detect_store) else $error("detected code not stored"); // see R17

  property p_self_run;
    @(posedge clock) disable iff (reset) (!generator_enable_r) |=> !self_check_run_r;
  endproperty
  a_self_run: assert property (p_self_run) else $error("self check ran while disabled"); // see R21

  c_short: cover property (@(posedge clock) disable iff (reset) short_packet_flag_r ##1 short_read);
  c_nsp:   cover property (@(posedge clock) disable iff (reset) new_sync_position_r ##[1:50] realign_r);
  c_self:  cover property (@(posedge clock) disable iff (reset) self_check_run_r && pass_r);
endmodule

// File: hw/video_regs_pkg.sv
// Shared constants, codes and carriers for the video format, framing and test register bank.
// Assumes one word clock and an 8-bit synchronous host control port on that clock.
// Contract
// R1: Near-full flag rises when queue occupancy reaches 90% of capacity; mappable to port.
// R2: Short-packet flag sets when a header arrives before the previous packet completes.
// R3: Parity mask set skips ID parity; clear checks and refuses parity-failing packets.
// R4: Vertical-blank extract enable allows packets on blanking lines, active and horizontal parts.
// R5: A forced-format code confines processing to that one format only, never ranges.
// R6: Format bit 4 means HD; bit 3 means PAL, also set for 24P HD.
// R7: Fourteen format codes follow the fixed table of SD and HD rasters.
// R8: High-def-only bit restricts lock search to the HD rate range. The code searches both ranges if the standard-def-only bit is also set.
// R9: Standard-def-only bit restricts lock search to the SD rate ranges. The code searches both ranges if the high-def-only bit is also set.
// R10: With both lock-only bits clear, search spans SD and HD rates.
// R11: Policy and permit clear: word alignment fixes on the first valid sync sequence.
// R12: Then off-boundary sync raises new-sync-position until an on-boundary sync arrives.
// R13: Policy set: realign as if new-sync-position fed the realign permit.
// R14: Host may instead wire new-sync-position to permit externally, policy left clear.
// R15: Policy clear and permit set: realign on every valid sync sequence.
// R16: Framing policy bit is 1 after power-on and every reset.
// R17: Detected format is stored automatically using the forced-format code set.
// R18: Detected HD code ignores the 1.001 rate difference.
// R19: Sync word bits 6, 7, 8 captured as H, V, F, held for the field.
// R20: Pattern choice selects output; HD bars, NTSC bars, PAL PLL serve self-test.
// R21: Generator enable runs both the pattern generator and the self-check. The code runs the self-check only for the R20 self-test patterns.
// R22: Self-check result bit reads 1 on pass, 0 on fail.
// R23: Pattern bit 5 HD, bit 4 progressive/PAL, bits 1:0 black/PLL/EQ/bars.
// R24: Registers are 8 bits; undocumented bits read zero.
package video_regs_pkg;

  // Register indices on the control port
  localparam logic [7:0] VIDEO_STANDARD_CONTROL_ADDR = 8'h0B;
  localparam logic [7:0] VIDEO_STANDARD_STATUS_ADDR  = 8'h0C;
  localparam logic [7:0] PATTERN_TEST_CONTROL_ADDR   = 8'h0D;
  localparam logic [7:0] AUX_EXTRACT_OPTIONS_ADDR    = 8'h18;

  // Control register fields
  localparam int CTL_HIGH_DEF_LOCK_ONLY_BIT = 5;
  localparam int CTL_STANDARD_DEF_LOCK_ONLY_BIT = 6;
  localparam int CTL_POLICY_BIT  = 7;
  localparam logic [7:0] VIDEO_STANDARD_CONTROL_RESET = 8'h80;

  // Pattern register fields
  localparam int TEST_ENABLE_BIT = 6;
  localparam int TEST_PASS_BIT   = 7;
  localparam logic [5:0] PATTERN_RESET = 6'h00;

  // Aux option fields
  localparam int AUX_NEAR_FULL_BIT  = 0;
  localparam int AUX_SHORT_BIT      = 1;
  localparam int AUX_PARITY_OFF_BIT = 2;
  localparam int AUX_VBLANK_BIT     = 3;
  localparam logic [1:0] AUX_OPTIONS_RESET = 2'h0;

  // Aux queue size and the 90% level, rounded up
  localparam int AUX_QUEUE_DEPTH     = 512;
  localparam int AUX_OCC_WIDTH       = 10;
  localparam int NEAR_FULL_PERCENT   = 90;
  localparam logic [AUX_OCC_WIDTH-1:0] NEAR_FULL_LEVEL =
    AUX_OCC_WIDTH'((AUX_QUEUE_DEPTH * NEAR_FULL_PERCENT + 99) / 100);

  // Video format codes
  typedef enum logic [4:0] {
    FMT_NONE     = 5'b00000,
    FMT_525_54   = 5'b00001,
    FMT_525_36   = 5'b00010,
    FMT_525_27   = 5'b00011,
    FMT_625_54   = 5'b01001,
    FMT_625_36   = 5'b01010,
    FMT_625_27   = 5'b01011,
    FMT_1035I    = 5'b10001,
    FMT_1080I30  = 5'b10010,
    FMT_1080P30  = 5'b10011,
    FMT_1080I25  = 5'b11001,
    FMT_1080P25  = 5'b11010,
    FMT_1250I25  = 5'b11100,
    FMT_1080P24  = 5'b11101,
    FMT_720P60   = 5'b10100
  } format_code_e; // see R6

  localparam int FMT_HD_BIT  = 4;
  localparam int FMT_PAL_BIT = 3;

  // Lock search range presented to the rate detector
  typedef enum logic [1:0] {
    LOCK_BOTH = 2'b00,
    LOCK_HD   = 2'b01,
    LOCK_SD   = 2'b10
  } lock_range_e;

  // Pattern kind in bits 1:0 of the choice word
  localparam int PAT_HD_BIT   = 5;
  localparam int PAT_PROG_BIT = 4;
  localparam logic [1:0] PAT_BLACK = 2'b00;
  localparam logic [1:0] PAT_PLL   = 2'b01;
  localparam logic [1:0] PAT_EQ    = 2'b10;
  localparam logic [1:0] PAT_BARS  = 2'b11;
  localparam logic [5:0] PAT_SD_NTSC_BARS = 6'h03;
  localparam logic [5:0] PAT_SD_PAL_PLL   = 6'h11;

  // Host access on the control port
  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_s;

  // Timing flags from a sync word: F, V, H
  typedef struct packed {
    logic f;
    logic v;
    logic h;
  } trs_flags_s;

endpackage

// File: hw/framing_ctrl.sv
// Word framing decision: when to take a new word alignment and the new-sync-position flag.
// Assumes sync detection and permit level are already on the word clock.
`timescale 1ns/1ps
module framing_ctrl (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic trs_valid,
  input  wire logic trs_on_boundary,
  input  wire logic policy,
  input  wire logic permit,
  output logic      aligned_r,
  output logic      realign_r,
  output logic      new_sync_position_r
);
  import video_regs_pkg::*;

  logic aligned_nxt;
  logic realign_nxt;
  logic nsp_nxt;
  logic realign_allowed;

  // Permit, or internal loop from the flag when policy is set
  assign realign_allowed = permit | (policy & new_sync_position_r); // see R13 R15

  // Next alignment state
  always_comb begin
    aligned_nxt = aligned_r;
    realign_nxt = 1'b0;
    nsp_nxt     = new_sync_position_r;
    if (trs_valid) begin
      if (!aligned_r || realign_allowed) begin
        aligned_nxt = 1'b1; // see R11
        realign_nxt = 1'b1;
        nsp_nxt     = 1'b0;
      end else if (!trs_on_boundary) begin
        nsp_nxt = 1'b1; // see R12
      end else begin
        nsp_nxt = 1'b0;
      end
    end
  end

  // Alignment registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      aligned_r           <= 1'b0;
      realign_r           <= 1'b0;
      new_sync_position_r <= 1'b0;
    end else begin
      aligned_r           <= aligned_nxt;
      realign_r           <= realign_nxt;
      new_sync_position_r <= nsp_nxt;
    end
  end

  property p_first_align;
    @(posedge clock) disable iff (reset) (trs_valid && !aligned_r) |=> (aligned_r && realign_r);
  endproperty
  a_first_align: assert property (p_first_align) else $error("first sync did not align"); // see R11

  property p_nsp_hold;
    @(posedge clock) disable iff (reset)
      (new_sync_position_r && !trs_valid && !realign_r) |=> new_sync_position_r;
  endproperty
  a_nsp_hold: assert property (p_nsp_hold) else $error("new sync flag dropped early"); // see R12

  property p_fixed_no_realign;
    @(posedge clock) disable iff (reset)
      (aligned_r && !policy && !permit && trs_valid) |=> !realign_r;
  endproperty
  a_fixed_no_realign: assert property (p_fixed_no_realign) else $error("realigned while fixed"); // see R11

  property p_permit_realign;
    @(posedge clock) disable iff (reset) (trs_valid && permit) |=> realign_r;
  endproperty
  a_permit_realign: assert property (p_permit_realign) else $error("permit did not realign"); // see R15

  property p_policy_loop;
    @(posedge clock) disable iff (reset)
      (policy && new_sync_position_r && trs_valid) |=> (realign_r && !new_sync_position_r);
  endproperty
  a_policy_loop: assert property (p_policy_loop) else $error("policy loop did not realign"); // see R13

  c_off_boundary: cover property (@(posedge clock) disable iff (reset)
    aligned_r && trs_valid && !trs_on_boundary && !policy && !permit);
endmodule

// File: bench/host_port_model.sv
// Host processor model on the control port: one register access per call.
// Assumes the block takes a request on a rising edge and answers just after it.
`timescale 1ns/1ps
module host_port_model (
  input  wire logic                 clock,
  input  wire logic [7:0]           rdata,
  output video_regs_pkg::host_req_s req
);
  import video_regs_pkg::*;
  // Idle bus from time zero
  initial req = '0;
  // Drive after an edge, hold through the taking edge, then sample and release
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock) #1;
    req = '{sel: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock) #1;
    q = rdata;
    req = '{sel: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d}; // Released lines lose the old value
  endtask
endmodule

// File: bench/tb_video_format_framing_test_regs.sv
// Self-checking bench for the format, framing, aux option and test register bank.
// Assumes the host model and the block share one 125 MHz clock.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_video_format_framing_test_regs;
  import video_regs_pkg::*;
  logic clock = 0, reset = 1, hdr = 0, done = 0, perr = 0, vbl = 0, dval = 0, tval = 0, onb = 0;
  logic scd = 0, scp = 0, permit = 0, loop = 0;
  logic [AUX_OCC_WIDTH-1:0] occ = '0;
  format_code_e             dcode = FMT_NONE, ff;
  trs_flags_s               flags = '0;
  host_req_s                req;
  lock_range_e              lr;
  logic [7:0]               rdata, q;
  logic [5:0]               pat;
  logic nf, sp, ext, fact, new_sync_position, ral, wal, gen, run;
  int num_errors = 0, check_count = 0, n_ext = 0, n_ral = 0;
  logic [7:0]   wv[3] = '{8'h2B, 8'h54, 8'h00};
  lock_range_e  lv[3] = '{LOCK_HD, LOCK_SD, LOCK_BOTH};
  format_code_e fv[3] = '{FMT_625_27, FMT_720P60, FMT_NONE};
  logic         av[3] = '{1'b1, 1'b1, 1'b0};
  logic [5:0]   pv[8] = '{6'h03, 6'h11, 6'h23, 6'h33, 6'h01, 6'h13, 6'h22, 6'h20};
  logic [7:0]   rv = 8'h0F;
  // Clock and pulse counters
  always #4 clock = ~clock;
  always @(posedge clock) begin
    n_ext += int'(ext);
    n_ral += int'(ral);
  end
  host_port_model host (.clock(clock), .rdata(rdata), .req(req));
  video_format_framing_test_regs dut (
    .clock(clock), .reset(reset), .host_req(req), .host_rdata_r(rdata), .aux_queue_occupancy(occ),
    .aux_packet_header(hdr), .aux_packet_done(done), .aux_packet_id_parity_error(perr),
    .aux_packet_on_vblank_line(vbl), .detect_valid(dval), .detect_code(dcode), .trs_valid(tval),
    .trs_on_boundary(onb), .trs_flags(flags), .self_check_done(scd), .self_check_pass(scp),
    .realign_input(permit | (loop & new_sync_position)), .aux_queue_near_full_flag_r(nf), .short_packet_flag_r(sp),
    .aux_packet_extract_r(ext), .forced_format_r(ff), .forced_format_active_r(fact), .lock_range_r(lr),
    .new_sync_position_r(new_sync_position), .realign_r(ral), .word_aligned_r(wal), .pattern_choice_r(pat),
    .generator_enable_r(gen), .self_check_run_r(run)
  );
  // Bench helpers
  task tick(int n = 1);
    repeat (n) @(posedge clock) #1;
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask
  task rchk(logic [7:0] a, logic [7:0] e);
    host.access(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask
  task trs(logic b);
    onb = b;
    tval = 1;
    tick();
    tval = 0;
    tick(3);
  endtask
  task head(logic pe, logic vb, logic cl);
    perr = pe;
    vbl = vb;
    hdr = 1;
    tick();
    hdr = 0;
    done = cl;
    tick();
    done = 0;
    tick();
  endtask
  task summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #160000;
    num_errors++;
    summarize();
  end
  // Test sequence
  initial begin
    tick(20);
    reset = 0;
    tick();
    rchk(VIDEO_STANDARD_CONTROL_ADDR, 8'h80);
    `CHK(lr, LOCK_BOTH)
    for (int i = 0; i < 3; i++) begin
      wr(VIDEO_STANDARD_CONTROL_ADDR, wv[i]);
      tick(2);
      `CHK(lr, lv[i])
      `CHK(ff, fv[i])
      `CHK(fact, av[i])
      rchk(VIDEO_STANDARD_CONTROL_ADDR, wv[i]);
    end
    wr(8'h10, 8'hFF);
    rchk(8'h10, 8'h00);
    // Framing with policy and permit clear, then with permit set, then with policy set
    flags = '{f: 1'b1, v: 1'b0, h: 1'b1};
    dcode = FMT_1080P24;
    dval = 1;
    tick();
    dval = 0;
    trs(1'b1);
    `CHK(n_ral, 1)
    `CHK(wal, 1'b1)
    rchk(VIDEO_STANDARD_STATUS_ADDR, 8'hBD);
    wr(VIDEO_STANDARD_STATUS_ADDR, 8'h00);
    rchk(VIDEO_STANDARD_STATUS_ADDR, 8'hBD);
    trs(1'b0);
    `CHK(new_sync_position, 1'b1)
    `CHK(n_ral, 1)
    trs(1'b1);
    `CHK(new_sync_position, 1'b0)
    permit = 1;
    tick(4);
    trs(1'b1);
    `CHK(n_ral, 2)
    permit = 0;
    wr(VIDEO_STANDARD_CONTROL_ADDR, 8'h80);
    tick(4);
    trs(1'b0);
    `CHK(new_sync_position, 1'b1)
    trs(1'b0);
    `CHK(n_ral, 3)
    `CHK(new_sync_position, 1'b0)
    // Host wires the new-sync flag back to the permit pin, policy clear
    wr(VIDEO_STANDARD_CONTROL_ADDR, 8'h00);
    loop = 1;
    trs(1'b0);
    `CHK(new_sync_position, 1'b1)
    trs(1'b0);
    `CHK(n_ral, 4)
    `CHK(new_sync_position, 1'b0)
    loop = 0;
    // Aux extraction options and flags
    head(1'b1, 1'b0, 1'b1);
    `CHK(n_ext, 0)
    wr(AUX_EXTRACT_OPTIONS_ADDR, 8'hF4);
    head(1'b1, 1'b0, 1'b1);
    `CHK(n_ext, 1)
    head(1'b0, 1'b1, 1'b1);
    `CHK(n_ext, 1)
    wr(AUX_EXTRACT_OPTIONS_ADDR, 8'h08);
    head(1'b0, 1'b1, 1'b1);
    `CHK(n_ext, 2)
    head(1'b0, 1'b0, 1'b0);
    head(1'b0, 1'b0, 1'b1);
    `CHK(sp, 1'b1)
    rchk(AUX_EXTRACT_OPTIONS_ADDR, 8'h0A);
    rchk(AUX_EXTRACT_OPTIONS_ADDR, 8'h08);
    occ = 10'h1CC;
    tick(3);
    `CHK(nf, 1'b0)
    occ = 10'h1CD;
    tick(3);
    `CHK(nf, 1'b1)
    rchk(AUX_EXTRACT_OPTIONS_ADDR, 8'h09);
    // Pattern generator and self-check
    wr(PATTERN_TEST_CONTROL_ADDR, 8'hC3);
    tick(2);
    `CHK({gen, pat, run}, 8'h87)
    rchk(PATTERN_TEST_CONTROL_ADDR, 8'h43);
    scp = 1;
    scd = 1;
    tick();
    scd = 0;
    tick();
    rchk(PATTERN_TEST_CONTROL_ADDR, 8'hC3);
    for (int i = 0; i < 8; i++) begin
      wr(PATTERN_TEST_CONTROL_ADDR, {2'b01, pv[i]});
      tick(2);
      `CHK(run, rv[i])
    end
    wr(PATTERN_TEST_CONTROL_ADDR, 8'h03);
    tick(2);
    `CHK({gen, run}, 2'b00)
    summarize();
  end
endmodule
